// ==== core/codec_ctl_defs.svh ====
`ifndef CODEC_CTL_DEFS_SVH
`define CODEC_CTL_DEFS_SVH

// Host register addresses
`define CC_ADDR_CTRL 8'h0B
`define CC_ADDR_INIT_PUSH 8'h12
`define CC_ADDR_WORD_COUNT 8'h24
`define CC_ADDR_SVC_ACK 8'h2E
`define CC_ADDR_ENC_STREAM 8'h30
`define CC_ADDR_STATUS 8'h40

// Control byte layout
`define CC_SEL_HI 7
`define CC_SEL_LO 6
`define CC_PAYLOAD_HI 5
`define CC_BIT_ENABLE 0
`define CC_BIT_RESET 1
`define CC_PORTS_RSVD_HI 5
`define CC_PORTS_RSVD_LO 2
`define CC_TYPE_RSVD_HI 5
`define CC_TYPE_RSVD_LO 4
`define CC_TYPE_HI 3

// Codec types
`define CC_TYPE_RISE_UNPRIMED 4'h1
`define CC_TYPE_RISE_PRIMED 4'h2
`define CC_TYPE_FALL_UNPRIMED 4'h3
`define CC_TYPE_FALL_PRIMED 4'h4
`define CC_TYPE_PRESET 4'h5
`define CC_TYPE_RESET_VAL 4'h1

// Commands
`define CC_CMD_PORT_START 6'h01
`define CC_CMD_PORT_STOP 6'h02
`define CC_CMD_FIFO_CLEAR 6'h03
`define CC_CMD_FIFO_COUNT 6'h04
`define CC_CMD_FIFO_DATA 6'h05
`define CC_CMD_CODEC_RESET 6'h06
`define CC_CMD_CODEC_RUN 6'h07
`define CC_CMD_CODEC_SLEEP 6'h08
`define CC_CMD_ENABLE_LOW 6'h09
`define CC_CMD_ENABLE_HIGH 6'h0A
`define CC_CMD_RESET_LOW 6'h0B
`define CC_CMD_RESET_HIGH 6'h0C

// Acknowledge values and status
`define CC_ACK_OK 8'h01
`define CC_ACK_FAIL 8'h00
`define CC_STATUS_READY_BIT 15

// Init word FIFO and serial word
`define CC_WORD_W 16
`define CC_FIFO_DEPTH 16
`define CC_PTR_W 4
`define CC_CNT_W 5
`define CC_BITCNT_W 5

`endif

// ==== core/codec_ctl_pkg.sv ====
package codec_ctl_pkg;

  typedef enum logic [1:0] {
    SEL_PORTS,
    SEL_CODEC,
    SEL_COMMAND,
    SEL_RESERVED
  } subreg_sel_t;

  typedef enum logic {
    CTL_IDLE,
    CTL_EXEC
  } ctl_state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } host_req_t;

  typedef struct packed {
    logic edge_fall;
    logic primed;
    logic preset;
  } ssp_cfg_t;

endpackage

// ==== core/external_codec_control_cmd.sv ====
`timescale 1ns/100ps
`include "codec_ctl_defs.svh"

// Behaviour
// - Top two bits of a control byte pick a sub-register; low six bits are payload.
// - After each control write completes, ready status bit 15 sets; interrupt if enabled.
// - Every control write leaves success or failure in service acknowledge; reserved values fail.
// - Port sub-register bit 0 drives the codec enable port level.
// - Port sub-register bit 1 drives the codec reset port level.
// - Codec types 1 to 4 choose sampling edge and FIFO priming of the serial port.
// - Type 5 selects the built-in codec preset; types 0 and 6-15 fail.
// - Command 01 starts the serial port and sends preloaded words; fails if running.
// - Command 02 stops the serial port; fails when the port is not running.
// - Command 03 empties the init word FIFO and clears the word count.
// - Command 04 copies FIFO word count; clears and pushes also refresh it.
// - Command 05 streams FIFO words into encoder output, high byte first.
// - Commands 06-08 reset, run or sleep the preset codec; no effect when generic.
// - Commands 09-0C set enable or reset port low or high individually.
// - Commands 00 and 0D-3F and select value 11 are reserved and fail.
module external_codec_control_cmd (
  // System clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Host register port
  input codec_ctl_pkg::host_req_t host_req_i,
  output logic [15:0] rdata_o,
  output logic busy_o,
  // Interrupt
  input wire logic irq_enable_i,
  output logic interrupt_out_n_o,
  // Codec control ports
  output logic codec_enable_port_o,
  output logic codec_reset_port_o,
  // Serial port configuration and state
  output codec_ctl_pkg::ssp_cfg_t ssp_cfg_o,
  output logic ssp_running_o,
  // Serial link, link clock domain
  input wire logic sclk_i,
  input wire logic ssp_frame_sync_i,
  output logic ssp_dout_o
);

  codec_ctl_pkg::ctl_state_t state_q;
  codec_ctl_pkg::subreg_sel_t sel;
  logic [`CC_PAYLOAD_HI:0] payload;
  logic [7:0] ctl_q;
  logic accept;
  logic exec;

  // Decode results, valid only during execution
  logic ok_c;
  logic en_we_c;
  logic en_val_c;
  logic rs_we_c;
  logic rs_val_c;
  logic type_we_c;
  logic start_c;
  logic stop_c;
  logic clear_c;
  logic count_c;
  logic drain_c;

  logic [3:0] codec_type_q;
  logic enable_q;
  logic reset_q;
  logic running_q;
  logic ready_q;
  logic [7:0] ack_q;
  logic [15:0] rdata_q;
  logic [`CC_CNT_W-1:0] word_count_q;
  logic refresh_q;
  logic drain_q;
  logic byte_hi_q;

  // FIFO
  logic push;
  logic pop;
  logic [`CC_WORD_W-1:0] head;
  logic [`CC_CNT_W-1:0] fifo_count;
  logic fifo_empty;
  logic stream_rd;
  logic send;

  // Crossing to link domain
  logic req_tgl_q;
  logic [`CC_WORD_W-1:0] tx_word_q;
  logic ack_tgl;
  logic ack_s1_q;
  logic ack_s2_q;
  logic pending;
  logic generic_type;

  assign sel = codec_ctl_pkg::subreg_sel_t'(ctl_q[`CC_SEL_HI:`CC_SEL_LO]);
  assign payload = ctl_q[`CC_PAYLOAD_HI:0];
  // Writes during execution are dropped, so one command runs at a time
  assign accept = host_req_i.wr && (host_req_i.addr == `CC_ADDR_CTRL) && (state_q == codec_ctl_pkg::CTL_IDLE);
  assign exec = (state_q == codec_ctl_pkg::CTL_EXEC);
  assign generic_type = (codec_type_q != `CC_TYPE_PRESET);

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_q <= codec_ctl_pkg::CTL_IDLE;
      ctl_q <= '0;
    end else begin
      unique case (state_q)
        codec_ctl_pkg::CTL_IDLE: begin
          if (accept) begin
            ctl_q <= host_req_i.wdata[7:0];
            state_q <= codec_ctl_pkg::CTL_EXEC;
          end
        end
        codec_ctl_pkg::CTL_EXEC: begin
          state_q <= codec_ctl_pkg::CTL_IDLE;
        end
      endcase
    end
  end

  always_comb begin
    ok_c = 1'b0;
    en_we_c = 1'b0;
    en_val_c = 1'b0;
    rs_we_c = 1'b0;
    rs_val_c = 1'b0;
    type_we_c = 1'b0;
    start_c = 1'b0;
    stop_c = 1'b0;
    clear_c = 1'b0;
    count_c = 1'b0;
    drain_c = 1'b0;
    if (exec) begin
      unique case (sel)
        codec_ctl_pkg::SEL_PORTS: begin
          // Reserved payload bits set make the write fail with no effect
          if (payload[`CC_PORTS_RSVD_HI:`CC_PORTS_RSVD_LO] == '0) begin
            ok_c = 1'b1;
            en_we_c = 1'b1;
            en_val_c = payload[`CC_BIT_ENABLE];
            rs_we_c = 1'b1;
            rs_val_c = payload[`CC_BIT_RESET];
          end
        end
        codec_ctl_pkg::SEL_CODEC: begin
          if (payload[`CC_TYPE_RSVD_HI:`CC_TYPE_RSVD_LO] == '0 &&
              payload[`CC_TYPE_HI:0] >= `CC_TYPE_RISE_UNPRIMED &&
              payload[`CC_TYPE_HI:0] <= `CC_TYPE_PRESET) begin
            ok_c = 1'b1;
            type_we_c = 1'b1;
          end
        end
        codec_ctl_pkg::SEL_COMMAND: begin
          unique case (payload)
            `CC_CMD_PORT_START: begin
              ok_c = !running_q;
              start_c = !running_q;
            end
            `CC_CMD_PORT_STOP: begin
              ok_c = running_q;
              stop_c = running_q;
            end
            `CC_CMD_FIFO_CLEAR: begin
              ok_c = 1'b1;
              clear_c = 1'b1;
            end
            `CC_CMD_FIFO_COUNT: begin
              ok_c = 1'b1;
              count_c = 1'b1;
            end
            `CC_CMD_FIFO_DATA: begin
              ok_c = 1'b1;
              drain_c = 1'b1;
            end
            `CC_CMD_CODEC_RESET: begin
              ok_c = 1'b1;
              rs_we_c = !generic_type;
              rs_val_c = 1'b0;
            end
            `CC_CMD_CODEC_RUN: begin
              ok_c = 1'b1;
              rs_we_c = !generic_type;
              rs_val_c = 1'b1;
              en_we_c = !generic_type;
              en_val_c = 1'b1;
            end
            `CC_CMD_CODEC_SLEEP: begin
              ok_c = 1'b1;
              en_we_c = !generic_type;
              en_val_c = 1'b0;
            end
            `CC_CMD_ENABLE_LOW, `CC_CMD_ENABLE_HIGH: begin
              ok_c = 1'b1;
              en_we_c = 1'b1;
              en_val_c = (payload == `CC_CMD_ENABLE_HIGH);
            end
            `CC_CMD_RESET_LOW, `CC_CMD_RESET_HIGH: begin
              ok_c = 1'b1;
              rs_we_c = 1'b1;
              rs_val_c = (payload == `CC_CMD_RESET_HIGH);
            end
            default: begin
              ok_c = 1'b0;
            end
          endcase
        end
        codec_ctl_pkg::SEL_RESERVED: begin
          ok_c = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      enable_q <= 1'b0;
      reset_q <= 1'b0;
    end else begin
      if (en_we_c) begin
        enable_q <= en_val_c;
      end
      if (rs_we_c) begin
        reset_q <= rs_val_c;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      codec_type_q <= `CC_TYPE_RESET_VAL;
    end else if (type_we_c) begin
      codec_type_q <= payload[`CC_TYPE_HI:0];
    end
  end

  // Edge and priming follow the selected type; the preset samples on the rising edge
  always_comb begin
    ssp_cfg_o.edge_fall = (codec_type_q == `CC_TYPE_FALL_UNPRIMED) ||
                          (codec_type_q == `CC_TYPE_FALL_PRIMED);
    ssp_cfg_o.primed = (codec_type_q == `CC_TYPE_RISE_PRIMED) ||
                       (codec_type_q == `CC_TYPE_FALL_PRIMED);
    ssp_cfg_o.preset = (codec_type_q == `CC_TYPE_PRESET);
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      running_q <= 1'b0;
    end else if (start_c) begin
      running_q <= 1'b1;
    end else if (stop_c) begin
      running_q <= 1'b0;
    end
  end

  // Ready and acknowledge; completion setting wins over a status read clear
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ready_q <= 1'b0;
      ack_q <= `CC_ACK_FAIL;
    end else if (exec) begin
      ready_q <= 1'b1;
      ack_q <= ok_c ? `CC_ACK_OK : `CC_ACK_FAIL;
    end else if (accept) begin
      ready_q <= 1'b0;
    end else if (host_req_i.rd && host_req_i.addr == `CC_ADDR_STATUS) begin
      ready_q <= 1'b0;
    end
  end

  assign interrupt_out_n_o = !(ready_q && irq_enable_i);
  assign busy_o = (state_q != codec_ctl_pkg::CTL_IDLE);

  // FIFO of codec initialisation words
  assign push = host_req_i.wr && (host_req_i.addr == `CC_ADDR_INIT_PUSH);
  assign stream_rd = host_req_i.rd && (host_req_i.addr == `CC_ADDR_ENC_STREAM);
  assign pop = (drain_q && stream_rd && !byte_hi_q) || send;

  init_word_fifo u_fifo (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .push_i(push),
    .push_data_i(host_req_i.wdata),
    .pop_i(pop),
    .clear_i(clear_c),
    .head_o(head),
    .count_o(fifo_count),
    .empty_o(fifo_empty),
    .full_o()
  );

  // Count snapshot lags a push or count command by one cycle; a clear zeroes it at once
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      refresh_q <= 1'b0;
      word_count_q <= '0;
    end else begin
      refresh_q <= push || count_c;
      if (clear_c) begin
        word_count_q <= '0;
      end else if (refresh_q) begin
        word_count_q <= fifo_count;
      end
    end
  end

  // Drain: stream register returns high byte then low byte of the head word
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      drain_q <= 1'b0;
      byte_hi_q <= 1'b1;
    end else if (drain_c) begin
      drain_q <= !fifo_empty;
      byte_hi_q <= 1'b1;
    end else if (clear_c) begin
      drain_q <= 1'b0;
      byte_hi_q <= 1'b1;
    end else if (drain_q && stream_rd) begin
      byte_hi_q <= !byte_hi_q;
      if (!byte_hi_q && fifo_count == `CC_CNT_W'(1)) begin
        drain_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_q <= '0;
    end else if (host_req_i.rd) begin
      unique case (host_req_i.addr)
        `CC_ADDR_STATUS: rdata_q <= {ready_q, 15'h0000};
        `CC_ADDR_SVC_ACK: rdata_q <= {8'h00, ack_q};
        `CC_ADDR_WORD_COUNT: rdata_q <= {11'h000, word_count_q};
        `CC_ADDR_ENC_STREAM: begin
          if (drain_q) begin
            rdata_q <= {8'h00, byte_hi_q ? head[15:8] : head[7:0]};
          end else begin
            rdata_q <= '0;
          end
        end
        default: rdata_q <= '0;
      endcase
    end
  end

  assign rdata_o = rdata_q;

  // Sender hands one word at a time to the link domain by toggle handshake
  assign pending = (req_tgl_q != ack_s2_q);
  assign send = running_q && !drain_q && !fifo_empty && !pending && !clear_c && !exec;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
    end else begin
      ack_s1_q <= ack_tgl;
      ack_s2_q <= ack_s1_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      req_tgl_q <= 1'b0;
      tx_word_q <= '0;
    end else if (send) begin
      req_tgl_q <= !req_tgl_q;
      tx_word_q <= head;
    end
  end

  // After a stop the link finishes any word already in flight, then idles
  serial_link_tx u_link (
    .sclk_i(sclk_i),
    .rst_n_i(rst_n_i),
    .run_i(running_q),
    .req_tgl_i(req_tgl_q),
    .word_i(tx_word_q),
    .ack_tgl_o(ack_tgl),
    .frame_sync_i(ssp_frame_sync_i),
    .dout_o(ssp_dout_o)
  );

  assign codec_enable_port_o = enable_q;
  assign codec_reset_port_o = reset_q;
  assign ssp_running_o = running_q;

endmodule

// ==== core/init_word_fifo.sv ====
`timescale 1ns/100ps
`include "codec_ctl_defs.svh"

module init_word_fifo (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Control
  input wire logic push_i,
  input wire logic [`CC_WORD_W-1:0] push_data_i,
  input wire logic pop_i,
  input wire logic clear_i,
  // State
  output logic [`CC_WORD_W-1:0] head_o,
  output logic [`CC_CNT_W-1:0] count_o,
  output logic empty_o,
  output logic full_o
);

  logic [`CC_WORD_W-1:0] mem_q [`CC_FIFO_DEPTH];
  logic [`CC_PTR_W-1:0] wr_ptr_q;
  logic [`CC_PTR_W-1:0] rd_ptr_q;
  logic [`CC_CNT_W-1:0] count_q;
  logic do_push;
  logic do_pop;

  assign empty_o = (count_q == '0);
  assign full_o = (count_q == `CC_CNT_W'(`CC_FIFO_DEPTH));
  // Pushes into a full FIFO are dropped
  assign do_push = push_i && !full_o && !clear_i;
  assign do_pop = pop_i && !empty_o && !clear_i;
  assign head_o = mem_q[rd_ptr_q];
  assign count_o = count_q;

  genvar i;
  generate
    for (i = 0; i < `CC_FIFO_DEPTH; i++) begin : g_entry
      always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
          mem_q[i] <= '0;
        end else if (do_push && wr_ptr_q == `CC_PTR_W'(i)) begin
          mem_q[i] <= push_data_i;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (!rst_n_i || clear_i) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_q <= wr_ptr_q + `CC_PTR_W'(1);
      end
      if (do_pop) begin
        rd_ptr_q <= rd_ptr_q + `CC_PTR_W'(1);
      end
      if (do_push && !do_pop) begin
        count_q <= count_q + `CC_CNT_W'(1);
      end else if (do_pop && !do_push) begin
        count_q <= count_q - `CC_CNT_W'(1);
      end
    end
  end

endmodule

// ==== core/serial_link_tx.sv ====
`timescale 1ns/100ps
`include "codec_ctl_defs.svh"

module serial_link_tx (
  // Link clock and system reset
  input wire logic sclk_i,
  input wire logic rst_n_i,
  // From system domain
  input wire logic run_i,
  input wire logic req_tgl_i,
  input wire logic [`CC_WORD_W-1:0] word_i,
  output logic ack_tgl_o,
  // Link pins
  input wire logic frame_sync_i,
  output logic dout_o
);

  logic rst_s1_q;
  logic rst_s2_q;
  logic run_s1_q;
  logic run_s2_q;
  logic req_s1_q;
  logic req_s2_q;
  logic fs_s1_q;
  logic fs_s2_q;
  logic fs_s3_q;
  logic ack_q;
  logic [`CC_WORD_W-1:0] shift_q;
  logic [`CC_BITCNT_W-1:0] bits_q;
  logic dout_q;
  logic start;

  always_ff @(posedge sclk_i) begin
    rst_s1_q <= rst_n_i;
    rst_s2_q <= rst_s1_q;
  end

  always_ff @(posedge sclk_i) begin
    if (!rst_s2_q) begin
      run_s1_q <= 1'b0;
      run_s2_q <= 1'b0;
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      fs_s1_q <= 1'b0;
      fs_s2_q <= 1'b0;
      fs_s3_q <= 1'b0;
    end else begin
      run_s1_q <= run_i;
      run_s2_q <= run_s1_q;
      req_s1_q <= req_tgl_i;
      req_s2_q <= req_s1_q;
      fs_s1_q <= frame_sync_i;
      fs_s2_q <= fs_s1_q;
      fs_s3_q <= fs_s2_q;
    end
  end

  // Words go out only once the codec is framing data
  assign start = run_s2_q && (req_s2_q != ack_q) && (bits_q == '0) && fs_s2_q && !fs_s3_q;

  always_ff @(posedge sclk_i) begin
    if (!rst_s2_q) begin
      shift_q <= '0;
      bits_q <= '0;
      ack_q <= 1'b0;
      dout_q <= 1'b0;
    end else if (start) begin
      shift_q <= word_i;
      bits_q <= `CC_BITCNT_W'(`CC_WORD_W);
    end else if (bits_q != '0) begin
      dout_q <= shift_q[`CC_WORD_W-1];
      shift_q <= {shift_q[`CC_WORD_W-2:0], 1'b0};
      bits_q <= bits_q - `CC_BITCNT_W'(1);
      if (bits_q == `CC_BITCNT_W'(1)) begin
        ack_q <= req_s2_q;
      end
    end
  end

  assign ack_tgl_o = ack_q;
  assign dout_o = dout_q;

endmodule

// ==== dv/codec_ctl_props.sv ====
`timescale 1ns/100ps
module codec_ctl_props (
  // System clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Host port
  input codec_ctl_pkg::host_req_t host_req_i,
  input wire logic [15:0] rdata_o,
  input wire logic busy_o,
  // Interrupt
  input wire logic irq_enable_i,
  input wire logic interrupt_out_n_o,
  // Codec ports and link
  input wire logic codec_enable_port_o,
  input wire logic codec_reset_port_o,
  input codec_ctl_pkg::ssp_cfg_t ssp_cfg_o,
  input wire logic ssp_running_o,
  input wire logic sclk_i,
  input wire logic ssp_frame_sync_i,
  input wire logic ssp_dout_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic acc;
  logic [7:0] b;
  assign b = host_req_i.wdata[7:0];
  assign acc = host_req_i.wr && host_req_i.addr == 8'h0B && !busy_o;

  a_busy_pulse: assert property (acc |=> busy_o ##1 !busy_o)
    else $error("busy is not one cycle after a control accept");
  a_busy_cause: assert property ($rose(busy_o) |-> $past(acc))
    else $error("busy rose without a control accept");
  a_irq_masked: assert property (!irq_enable_i |-> interrupt_out_n_o)
    else $error("interrupt low while disabled");
  a_irq_done: assert property (acc ##2 irq_enable_i |-> !interrupt_out_n_o)
    else $error("no interrupt at control completion");
  a_port_bits: assert property (acc && b[7:2] == 6'h00 |-> ##2
    codec_enable_port_o == $past(b[0], 2) && codec_reset_port_o == $past(b[1], 2))
    else $error("port levels differ from written bits");
  a_port_rsvd: assert property (acc && b[7:6] == 2'b00 && b[5:2] != 4'h0 |-> ##2
    codec_enable_port_o == $past(codec_enable_port_o, 2))
    else $error("rejected port write changed the enable port");
  a_cmd_enable: assert property (acc && b == 8'h8A |-> ##2
    codec_enable_port_o && codec_reset_port_o == $past(codec_reset_port_o, 2))
    else $error("enable high command wrong");
  a_cmd_reset_lo: assert property (acc && b == 8'h8B |-> ##2
    !codec_reset_port_o && codec_enable_port_o == $past(codec_enable_port_o, 2))
    else $error("reset low command wrong");
  a_port_change: assert property ($changed(codec_enable_port_o) || $changed(codec_reset_port_o)
    |-> $past(busy_o))
    else $error("port moved outside a control action");
  a_cfg_change: assert property ($changed(ssp_cfg_o) |-> $past(busy_o))
    else $error("serial config moved outside a control action");
  a_run_change: assert property ($changed(ssp_running_o) |-> $past(busy_o))
    else $error("running moved outside a control action");

  c_irq: cover property (acc ##2 !interrupt_out_n_o);
  c_run: cover property ($rose(ssp_running_o));
  c_preset: cover property ($rose(ssp_cfg_o.preset));
endmodule

bind external_codec_control_cmd codec_ctl_props u_codec_ctl_props (.clk_i, .rst_n_i, .host_req_i, .rdata_o,
  .busy_o, .irq_enable_i, .interrupt_out_n_o, .codec_enable_port_o, .codec_reset_port_o, .ssp_cfg_o,
  .ssp_running_o, .sclk_i, .ssp_frame_sync_i, .ssp_dout_o);

// ==== dv/codec_link_model.sv ====
`timescale 1ns/100ps
module codec_link_model (
  // Frame request from the bench
  input wire logic run_i,
  // Link pins
  output logic sclk_o,
  output logic frame_sync_o,
  input wire logic dout_i,
  // Bits seen on the link
  output logic [31:0] cap_o
);
  task automatic tick();
    #6 sclk_o = 1'b1;
    #6 sclk_o = 1'b0;
    cap_o = {cap_o[30:0], dout_i};
  endtask

  // Each rise of run_i gives one frame: clock runs 4 ticks before, 24 inside and 2 after it
  initial begin
    sclk_o = 1'b0;
    frame_sync_o = 1'b0;
    cap_o = '0;
    forever begin
      wait (run_i);
      repeat (4) tick();
      frame_sync_o = 1'b1;
      repeat (24) tick();
      frame_sync_o = 1'b0;
      repeat (2) tick();
      wait (!run_i);
    end
  end
endmodule

// ==== dv/external_codec_control_cmd_tb.sv ====
`timescale 1ns/100ps
module external_codec_control_cmd_tb;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic irq_en = 1'b1;
  logic run_link = 1'b1;
  logic sclk, fs, dout, busy, int_n, en, rst, running;
  logic [15:0] rdata;
  logic [31:0] cap;
  codec_ctl_pkg::host_req_t req = '0;
  codec_ctl_pkg::ssp_cfg_t cfg;
  int err_count = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [7:0] rsv [5] = '{8'h80, 8'h8D, 8'hBF, 8'hC0, 8'hFF};
  logic [15:0] words [3] = '{16'h12AB, 16'h34CD, 16'hF00E};

  always #10 clk_i = ~clk_i;

  external_codec_control_cmd u_external_codec_control_cmd (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .host_req_i(req), .rdata_o(rdata), .busy_o(busy), .irq_enable_i(irq_en), .interrupt_out_n_o(int_n),
    .codec_enable_port_o(en), .codec_reset_port_o(rst), .ssp_cfg_o(cfg), .ssp_running_o(running),
    .sclk_i(sclk), .ssp_frame_sync_i(fs), .ssp_dout_o(dout));
  codec_link_model u_codec_link_model (.run_i(run_link), .sclk_o(sclk), .frame_sync_o(fs), .dout_i(dout),
    .cap_o(cap));

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_i);
    req <= '0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk_i);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge clk_i);
    req <= '0;
    @(posedge clk_i);
    #1 d = rdata;
  endtask

  // Waits out the command before touching any other register
  task automatic ctl(input logic [7:0] b, input logic ok);
    logic [15:0] d;
    wr(8'h0B, {8'h00, b});
    #1 chk("busy", busy, 1'b1);
    @(posedge clk_i);
    @(posedge clk_i);
    #1 chk("busy end", busy, 1'b0);
    chk("irq", int_n, !irq_en);
    rd(8'h40, d);
    chk("ready", d[15], 1'b1);
    rd(8'h2E, d);
    chk("ack", d[7:0], ok ? 8'h01 : 8'h00);
  endtask

  task automatic cp(input logic [7:0] b, input logic ok, input logic [1:0] er);
    ctl(b, ok);
    chk("ports", {rst, en}, er);
  endtask

  task automatic t_ports();
    @(posedge clk_i);
    irq_en <= 1'b0;
    cp(8'h03, 1'b1, 2'b11);
    @(posedge clk_i);
    irq_en <= 1'b1;
    cp(8'h01, 1'b1, 2'b01);
    cp(8'h02, 1'b1, 2'b10);
    cp(8'h07, 1'b0, 2'b10);
    cp(8'h20, 1'b0, 2'b10);
    cp(8'h00, 1'b1, 2'b00);
  endtask

  task automatic t_cmd_ports();
    cp(8'h8A, 1'b1, 2'b01);
    cp(8'h8C, 1'b1, 2'b11);
    cp(8'h89, 1'b1, 2'b10);
    cp(8'h8B, 1'b1, 2'b00);
    // Second write lands while busy and must be dropped
    // Strobe held so the second byte is sampled in the busy cycle
    @(posedge clk_i);
    req <= '{wr: 1'b1, rd: 1'b0, addr: 8'h0B, wdata: 16'h008A};
    @(posedge clk_i);
    req <= '{wr: 1'b1, rd: 1'b0, addr: 8'h0B, wdata: 16'h008C};
    @(posedge clk_i);
    req <= '0;
    repeat (3) @(posedge clk_i);
    #1 chk("refused", {rst, en}, 2'b01);
  endtask

  task automatic t_types();
    logic [2:0] e;
    logic ok;
    e = 3'b000;
    for (int t = 0; t < 16; t++) begin
      ok = (t >= 1 && t <= 5);
      ctl({4'h4, t[3:0]}, ok);
      if (ok) e = {t == 3 || t == 4, t == 2 || t == 4, t == 5};
      chk("cfg", cfg, e);
    end
    ctl(8'h51, 1'b0);
    chk("cfg", cfg, e);
    ctl(8'h41, 1'b1);
  endtask

  task automatic t_codec_cmds();
    cp(8'h02, 1'b1, 2'b10);
    cp(8'h86, 1'b1, 2'b10);
    cp(8'h87, 1'b1, 2'b10);
    cp(8'h88, 1'b1, 2'b10);
    ctl(8'h45, 1'b1);
    cp(8'h86, 1'b1, 2'b00);
    cp(8'h87, 1'b1, 2'b11);
    cp(8'h88, 1'b1, 2'b10);
    ctl(8'h41, 1'b1);
    foreach (rsv[i]) ctl(rsv[i], 1'b0);
  endtask

  task automatic t_fifo();
    logic [15:0] d;
    ctl(8'h83, 1'b1);
    rd(8'h24, d);
    chk("count", d, 16'h0000);
    foreach (words[i]) wr(8'h12, words[i]);
    rd(8'h24, d);
    chk("count", d, 16'h0003);
    ctl(8'h84, 1'b1);
    rd(8'h24, d);
    chk("count", d, 16'h0003);
    ctl(8'h85, 1'b1);
    foreach (words[i]) begin
      rd(8'h30, d);
      chk("hi", d[7:0], words[i][15:8]);
      rd(8'h30, d);
      chk("lo", d[7:0], words[i][7:0]);
    end
    rd(8'h30, d);
    chk("drained", d, 16'h0000);
    ctl(8'h83, 1'b1);
    rd(8'h24, d);
    chk("count", d, 16'h0000);
  endtask

  task automatic t_link();
    logic found;
    found = 1'b0;
    wr(8'h12, 16'hA5C3);
    ctl(8'h81, 1'b1);
    chk("run", running, 1'b1);
    ctl(8'h81, 1'b0);
    run_link = 1'b1;
    repeat (40) @(posedge clk_i);
    run_link = 1'b0;
    for (int i = 0; i <= 16; i++) if (cap[i+:16] === 16'hA5C3) found = 1'b1;
    chk("word", found, 1'b1);
    ctl(8'h82, 1'b1);
    chk("run", running, 1'b0);
    ctl(8'h82, 1'b0);
    ctl(8'h83, 1'b1);
  endtask

  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      conclude();
    end
  end

  // Link frame during reset gives the link domain its reset edges
  initial begin
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    run_link <= 1'b0;
    #1 chk("idle", {busy, int_n, en, rst, running, cfg}, 8'h40);
    t_ports();
    t_cmd_ports();
    t_types();
    t_codec_cmds();
    t_fifo();
    t_link();
    conclude();
  end
endmodule
